// [rtl/axi3_master_write_port.sv]
// write side of the 64-bit axi3 master port: takes a burst command and
// its beats from the core side and drives aw, w, b channels
// assumes the slave follows axi3 handshakes on the same clock
`timescale 1ns/100ps
module axi3_master_write_port
  import wr_port_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // core command side
  input wire logic cmd_valid,
  input wire wr_port_pkg::aw_t cmd,
  output logic cmd_ready,
  // core beat side
  input wire logic beat_valid,
  input wire wr_port_pkg::wbeat_t beat,
  output logic beat_ready,
  // core response side
  output logic rsp_valid,
  output wr_port_pkg::bresp_t rsp,
  input wire logic rsp_ready,
  // write address channel
  output logic awvalid,
  input wire logic awready,
  output logic [ID_W-1:0] master_write_addr_id,
  output logic [ADDR_W-1:0] master_write_addr,
  output logic [LEN_W-1:0] master_write_burst_len,
  output logic [1:0] master_write_beat_size,
  output logic [1:0] master_write_burst_type,
  output logic [1:0] master_write_lock_type,
  output logic [CACHE_W-1:0] master_write_cache_attr,
  output logic [2:0] awprot,
  output logic [AUSER_W-1:0] master_write_addr_user,
  // write data channel
  output logic wvalid,
  input wire logic wready,
  output logic [ID_W-1:0] wid,
  output logic [DATA_W-1:0] master_write_payload,
  output logic [STRB_W-1:0] master_write_byte_strobes,
  output logic master_write_final_beat,
  output logic [WUSER_W-1:0] master_write_data_user,
  // write response channel
  input wire logic bvalid,
  output logic master_write_resp_accept,
  input wire logic [ID_W-1:0] bid,
  input wire logic [1:0] master_write_resp_code
);
  import wr_port_pkg::*;

  typedef enum logic [1:0] {IDLE, ADDR, DATA} state_t;

  state_t state_q;
  state_t state_d;
  aw_t aw_q;
  wbeat_t w_q;
  logic wvalid_q;
  logic last_q;
  logic rspv_q;
  bresp_t rsp_q;
  logic [OUT_W-1:0] out_q;
  logic cmd_ready_q;
  logic beat_ready_q;
  logic bready_q;

  wire aw_fire = awvalid & awready;
  wire w_fire = wvalid_q & wready;
  wire b_fire = bvalid & bready_q;
  wire cmd_fire = cmd_valid & cmd_ready_q;
  wire beat_fire = beat_valid & beat_ready_q;
  wire rsp_fire = rspv_q & rsp_ready;
  wire final_beat;
  // the data slot is free when empty or being drained this cycle
  wire slot_free = ~wvalid_q | w_fire;
  // beats are only taken after the address is out, so wid is known
  wire beat_take_ok = (state_q == DATA) & ~(last_q & wvalid_q) & slot_free;
  // the response buffer holds one; stall new bursts when outstanding is full
  wire out_room = (out_q != OUT_W'(OUT_MAX));
  wire [OUT_W-1:0] out_d = out_q + OUT_W'(cmd_fire) - OUT_W'(b_fire);

  beat_counter u_beats (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(aw_fire),
    .len(aw_q.len),
    .advance(beat_fire),
    .final_beat(final_beat)
  );

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      IDLE: if (cmd_fire) state_d = ADDR;
      ADDR: if (aw_fire) state_d = DATA;
      DATA: if (w_fire & last_q) state_d = IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= IDLE;
      aw_q <= '0;
      w_q <= '0;
      wvalid_q <= 1'b0;
      last_q <= 1'b0;
      rspv_q <= 1'b0;
      rsp_q <= '0;
      out_q <= '0;
      cmd_ready_q <= 1'b0;
      beat_ready_q <= 1'b0;
      bready_q <= 1'b0;
    end else begin
      state_q <= state_d;
      out_q <= out_d;
      // payload held until the slave takes it
      if (cmd_fire) aw_q <= cmd;
      if (beat_fire) begin
        w_q <= beat;
        last_q <= final_beat;
      end
      if (beat_fire) wvalid_q <= 1'b1;
      else if (w_fire) wvalid_q <= 1'b0;
      if (b_fire) rsp_q <= '{id: bid, resp: master_write_resp_code};
      if (b_fire) rspv_q <= 1'b1;
      else if (rsp_fire) rspv_q <= 1'b0;
      cmd_ready_q <= (state_d == IDLE) & ~cmd_fire & out_room;
      // a beat taken now fills the slot next cycle, so ready must drop behind it
      beat_ready_q <= (state_d == DATA) & beat_take_ok & ~beat_fire;
      // one-deep response hold: accept only when it is empty
      bready_q <= ~(rspv_q & ~rsp_fire) & ~b_fire;
    end
  end

  assign cmd_ready = cmd_ready_q;
  assign beat_ready = beat_ready_q;
  assign awvalid = (state_q == ADDR);
  assign master_write_addr_id = aw_q.id;
  assign master_write_addr = aw_q.addr;
  assign master_write_burst_len = aw_q.len;
  assign master_write_beat_size = aw_q.size;
  assign master_write_burst_type = aw_q.burst;
  assign master_write_lock_type = aw_q.lock;
  assign master_write_cache_attr = aw_q.cache;
  assign awprot = aw_q.prot;
  assign master_write_addr_user = aw_q.user;
  assign wvalid = wvalid_q;
  assign wid = aw_q.id;
  assign master_write_payload = w_q.data;
  assign master_write_byte_strobes = w_q.strb;
  assign master_write_final_beat = last_q;
  assign master_write_data_user = w_q.user;
  assign rsp_valid = rspv_q;
  assign rsp = rsp_q;
  assign master_write_resp_accept = bready_q;
endmodule

// [rtl/wr_port_pkg.sv]
// shared types and constants for the 64-bit write master port
// assumes one clock, asynchronous active-high reset
package wr_port_pkg;
  localparam bit COHERENCY_PRESENT = 1'b0;
  localparam int COHERENCY_ID_WIDTH_PARAM = 4;
  localparam int ID_W = COHERENCY_PRESENT ? (COHERENCY_ID_WIDTH_PARAM + 1) : 5;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int STRB_W = DATA_W / 8;
  localparam int LEN_W = 4;
  localparam int CACHE_W = 4;
  localparam int AUSER_W = 11;
  localparam int WUSER_W = 2;
  localparam int OUT_MAX = 4;
  localparam int OUT_W = 3;
  localparam logic [1:0] BURST_INCR = 2'h1;
  localparam logic [1:0] BURST_WRAP = 2'h2;
  localparam logic [1:0] LOCK_NORMAL = 2'h0;
  localparam logic [1:0] SIZE_64 = 2'h3;
  localparam logic [LEN_W-1:0] LEN_ZERO = 4'h0;

  typedef struct packed {
    logic [ID_W-1:0] id;
    logic [ADDR_W-1:0] addr;
    logic [LEN_W-1:0] len;
    logic [1:0] size;
    logic [1:0] burst;
    logic [1:0] lock;
    logic [CACHE_W-1:0] cache;
    logic [2:0] prot;
    logic [AUSER_W-1:0] user;
  } aw_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [STRB_W-1:0] strb;
    logic [WUSER_W-1:0] user;
  } wbeat_t;

  typedef struct packed {
    logic [ID_W-1:0] id;
    logic [1:0] resp;
  } bresp_t;
endpackage

// [rtl/beat_counter.sv]
// counts data beats of the burst in flight and flags the final one
// assumes the caller loads len and pulses advance on each accepted beat
`timescale 1ns/100ps
module beat_counter
  import wr_port_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // control
  input wire logic load,
  input wire logic [LEN_W-1:0] len,
  input wire logic advance,
  // status
  output logic final_beat
);
  logic [LEN_W-1:0] left_q;
  logic [LEN_W-1:0] left_d;

  assign left_d = load ? len : (advance ? left_q - 4'h1 : left_q);
  assign final_beat = (left_q == LEN_ZERO);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      left_q <= LEN_ZERO;
    end else begin
      left_q <= left_d;
    end
  end
endmodule

// [tb/wp_monitor.sv]
// assertions on the write port's handshakes and burst framing
// bound to the top module; one clock, async active-high reset
`timescale 1ns/100ps
module wp_monitor
  import wr_port_pkg::*;
(
  // clock, reset and handshakes
  input logic clk_sys, rst, cmd_valid, cmd_ready, rsp_valid, rsp_ready, awvalid, awready,
  input logic wvalid, wready, master_write_final_beat, bvalid, master_write_resp_accept,
  // burst shape
  input logic [LEN_W-1:0] master_write_burst_len
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [LEN_W-1:0] beat_q;
  always_ff @(posedge clk_sys or posedge rst)
    if (rst) beat_q <= '0;
    else if (wvalid && wready) beat_q <= master_write_final_beat ? '0 : beat_q + 1'b1;
  sequence s_wst; wvalid && !wready; endsequence
  sequence s_bt; bvalid && master_write_resp_accept; endsequence
  property p_aw; awvalid && !awready |=> awvalid && $stable(master_write_burst_len); endproperty
  a_aw: assert property (p_aw) else $error("aw dropped");
  property p_w; s_wst |=> wvalid && $stable(master_write_final_beat); endproperty
  a_w: assert property (p_w) else $error("w dropped");
  property p_last; wvalid |-> master_write_final_beat == (beat_q == master_write_burst_len);
  endproperty
  a_last: assert property (p_last) else $error("last misplaced");
  property p_len; wvalid |-> $stable(master_write_burst_len); endproperty
  a_len: assert property (p_len) else $error("len moved");
  property p_cmd; cmd_valid && cmd_ready |=> awvalid; endproperty
  a_cmd: assert property (p_cmd) else $error("no aw");
  property p_busy; awvalid || wvalid |-> !cmd_ready; endproperty
  a_busy: assert property (p_busy) else $error("cmd in burst");
  property p_b; s_bt |=> rsp_valid && !master_write_resp_accept; endproperty
  a_b: assert property (p_b) else $error("b lost");
  property p_rsp; rsp_valid && !rsp_ready |=> rsp_valid; endproperty
  a_rsp: assert property (p_rsp) else $error("rsp dropped");
endmodule

// [tb/wr_slave_model.sv]
// slave stand-in: paced ready, one response per burst
// assumes one burst in flight at a time
`timescale 1ns/100ps
module wr_slave_model
  import wr_port_pkg::*;
(
  // inputs
  input logic clk_sys, rst, slow, awvalid, wvalid, master_write_final_beat,
  input logic master_write_resp_accept,
  input logic [1:0] code,
  input logic [ID_W-1:0] master_write_addr_id,
  // outputs
  output logic awready, wready, bvalid,
  output logic [ID_W-1:0] bid,
  output logic [1:0] master_write_resp_code
);
  logic [ID_W-1:0] id_q;
  logic [1:0] cnt_q;
  // slow mode opens ready one cycle in four so the master must hold
  assign awready = !slow || cnt_q == 2'h0;
  assign wready = awready;
  // idle lines show the inverse so a stale value never passes
  assign bid = bvalid ? id_q : ~id_q;
  assign master_write_resp_code = bvalid ? code : ~code;
  always_ff @(posedge clk_sys or posedge rst)
    if (rst) begin
      {cnt_q, id_q, bvalid} <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      if (awvalid && awready) id_q <= master_write_addr_id;
      if (wvalid && wready && master_write_final_beat) bvalid <= 1'b1;
      else if (master_write_resp_accept) bvalid <= 1'b0;
    end
endmodule

// [tb/axi3_master_write_port_test.sv]
// bench: bursts of every length against the slave model
// assumes package defaults, five-bit ids
`timescale 1ns/100ps
module axi3_master_write_port_test;
  import wr_port_pkg::*;
  logic clk_sys = 0, rst = 1, cmd_valid = 0, beat_valid = 0, rsp_ready = 0, slow = 0;
  logic cmd_ready, beat_ready, rsp_valid, awvalid, awready, wvalid, wready, bvalid;
  logic master_write_final_beat, master_write_resp_accept;
  logic [1:0] code = 0, master_write_beat_size, master_write_burst_type, master_write_lock_type;
  logic [1:0] master_write_resp_code, master_write_data_user;
  logic [2:0] awprot;
  logic [3:0] master_write_burst_len, master_write_cache_attr, exp_n = 0, bi = 0;
  logic [ID_W-1:0] master_write_addr_id, wid, bid;
  logic [7:0] master_write_byte_strobes;
  logic [10:0] master_write_addr_user;
  logic [31:0] master_write_addr;
  logic [63:0] master_write_payload;
  aw_t cmd = '0;
  wbeat_t beat = '0;
  bresp_t rsp;
  int fail_count = 0, n_checks = 0, cyc = 0;
  always #5 clk_sys = ~clk_sys;
  axi3_master_write_port u_dut (.*);
  wr_slave_model u_slave (.*);
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // n+1 beats; odd n meets a stalling slave, response codes cycle
  task automatic t_burst(input logic [3:0] n);
    {slow, code, exp_n} <= {n[0], n[1:0], n};
    cmd <= {ID_W'(n), 32'h0000_1000, n, SIZE_64, BURST_INCR, LOCK_NORMAL, ~n, 3'h0, 11'(n)};
    cmd_valid <= 1'b1;
    do @(negedge clk_sys); while (cmd_ready !== 1'b1);
    @(posedge clk_sys) cmd_valid <= 1'b0;
    for (int k = 0; k <= n; k++) begin
      beat <= {{8{n, 4'(k)}}, 8'hff >> k[2:0], 2'(k)};
      beat_valid <= 1'b1;
      do @(negedge clk_sys); while (beat_ready !== 1'b1);
      @(posedge clk_sys);
    end
    beat_valid <= 1'b0;
    do @(negedge clk_sys); while (rsp_valid !== 1'b1);
    chk({rsp.id, rsp.resp}, {ID_W'(n), n[1:0]}, "rsp");
    @(posedge clk_sys) rsp_ready <= 1'b1;
    @(posedge clk_sys) rsp_ready <= 1'b0;
  endtask
  always @(posedge clk_sys) begin
    if (!rst && awvalid && awready) begin
      chk({master_write_addr_id, master_write_burst_len}, {ID_W'(exp_n), exp_n}, "len");
      chk(master_write_cache_attr, 4'(~exp_n), "cache");
      chk(master_write_addr_user, 11'(exp_n), "auser");
      chk({master_write_addr, master_write_beat_size, master_write_burst_type,
        master_write_lock_type, awprot}, {32'h0000_1000, SIZE_64, BURST_INCR, LOCK_NORMAL,
        3'h0}, "attr");
    end
    if (!rst && wvalid && wready) begin
      chk(master_write_payload, {8{exp_n, bi}}, "data");
      chk(master_write_byte_strobes, 8'hff >> bi[2:0], "strb");
      chk({wid, master_write_data_user}, {ID_W'(exp_n), 2'(bi)}, "wid");
      chk(master_write_final_beat, bi == exp_n, "last");
      bi <= master_write_final_beat ? '0 : bi + 1'b1;
    end
    if (++cyc > 20000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    for (int n = 0; n < 16; n++) t_burst(4'(n));
    complete_run();
  end
endmodule
bind axi3_master_write_port wp_monitor u_mon (.*);
